// >>> verilog/pspf_pkg.sv
// Constants and types for the serial keyboard/mouse port with receive FIFO
package pspf_pkg;

	// ==========================================================
	// Register map
	localparam logic [31:0] DATA_ADDR  = 32'hFF20_0108;
	localparam logic [31:0] CTRL_ADDR  = 32'hFF20_010C;
	localparam logic [31:0] STAT_ADDR  = 32'hFF20_0110;
	localparam logic [31:0] MASK_ADDR  = 32'hFF20_0114;

	// ==========================================================
	// Field positions
	localparam int          BYTE_W     = 8;
	localparam int          VALID_BIT  = 15;
	localparam int          CNT_LSB    = 16;
	localparam int          CNT_W      = 16;
	localparam int          RE_BIT     = 0;
	localparam int          RI_BIT     = 8;
	localparam int          CE_BIT     = 10;
	localparam int          EV_W       = 4;
	localparam int          EV_RX      = 0;
	localparam int          EV_TXOK    = 1;
	localparam int          EV_TXERR   = 2;
	localparam int          EV_RXERR   = 3;

	// ==========================================================
	// Link framing and timing
	localparam int          FIFO_DEPTH = 256;
	localparam logic [3:0]  FRAME_LAST = 4'hA;
	localparam logic [3:0]  TX_LAST    = 4'h9;
	localparam int          CLK_NS     = 40;
	localparam int          INHIBIT_NS = 100000;
	localparam int          TIMEOUT_NS = 15000000;
	localparam int          INHIBIT_CYC = (INHIBIT_NS + CLK_NS - 1) / CLK_NS;
	localparam int          TIMEOUT_CYC = TIMEOUT_NS / CLK_NS;
	localparam int          TMR_W      = 19;

	typedef enum logic [2:0] {
		TX_IDLE,
		TX_INHIBIT,
		TX_START,
		TX_BITS,
		TX_ACK
	} pspf_tx_type;

endpackage : pspf_pkg

// >>> verilog/pspf_mem_if.sv
// Write and read port bundle between the port logic and its FIFO memory
`timescale 1ns/100ps
interface pspf_mem_if #(
	parameter int AW = 8,
	parameter int DW = 8
) ();
	logic          we;
	logic [AW-1:0] waddr;
	logic [DW-1:0] wdata;
	logic [AW-1:0] raddr;
	logic [DW-1:0] rdata;

	modport mem  (input we, waddr, wdata, raddr, output rdata);
	modport user (output we, waddr, wdata, raddr, input rdata);
endinterface : pspf_mem_if

// >>> verilog/pspf_fifo_mem.sv
// Receive FIFO storage with registered read data and write bypass
`timescale 1ns/100ps
module pspf_fifo_mem #(
	parameter int AW = 8,
	parameter int DW = 8
) (
	input  wire logic mclk,
	pspf_mem_if.mem   mp
);
	logic [DW-1:0] store [0:(2**AW)-1];
	logic [DW-1:0] rdata_reg;

	assign mp.rdata = rdata_reg;

	// A write to the address being read returns the new byte
	always_ff @(posedge mclk) begin
		if (mp.we) begin
			store[mp.waddr] <= mp.wdata;
		end
		if (mp.we && mp.waddr == mp.raddr) begin
			rdata_reg <= mp.wdata;
		end else begin
			rdata_reg <= store[mp.raddr];
		end
	end
endmodule : pspf_fifo_mem

// >>> verilog/pspf_port.sv
// Serial keyboard/mouse port: APB registers, receive FIFO, command sender
//
// Chosen here: register access over APB.
`timescale 1ns/100ps
module pspf_port #(
	parameter int DEPTH       = pspf_pkg::FIFO_DEPTH,
	parameter int TIMEOUT_CYC = pspf_pkg::TIMEOUT_CYC
) (
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        ps2ClkIn,
	output logic             ps2ClkOut,
	output logic             ps2ClkOeN,
	input  wire logic        ps2DatIn,
	output logic             ps2DatOut,
	output logic             ps2DatOeN,
	output logic             irq
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = AW + 1;
	localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
	localparam logic [pspf_pkg::TMR_W-1:0] TMO =
		pspf_pkg::TMR_W'(TIMEOUT_CYC);
	localparam logic [pspf_pkg::TMR_W-1:0] INH =
		pspf_pkg::TMR_W'(pspf_pkg::INHIBIT_CYC);

	typedef struct packed {
		logic                        pready;
		logic                        pslverr;
		logic [31:0]                 prdata;
		logic                        popPend;
		logic                        irq;
		logic                        clkS1;
		logic                        clkS2;
		logic                        clkS3;
		logic                        datS1;
		logic                        datS2;
		logic [AW-1:0]               wrPtr;
		logic [AW-1:0]               rdPtr;
		logic [CW-1:0]               cnt;
		logic                        re;
		logic                        ce;
		logic [pspf_pkg::EV_W-1:0]   stat;
		logic [pspf_pkg::EV_W-1:0]   mask;
		logic [10:0]                 rxSh;
		logic [3:0]                  rxBits;
		pspf_pkg::pspf_tx_type       tx;
		logic [9:0]                  txSh;
		logic [3:0]                  txBits;
		logic [pspf_pkg::TMR_W-1:0]  timer;
		logic                        clkOeN;
		logic                        datOeN;
	} pspf_state_type;

	pspf_state_type st_reg;
	pspf_state_type st_next;

	pspf_mem_if #(.AW(AW), .DW(pspf_pkg::BYTE_W)) memIf ();

	logic                      push;
	logic                      pop;
	logic                      fall;
	logic                      txFail;
	logic                      txOk;
	logic [10:0]               frame;
	logic [pspf_pkg::EV_W-1:0] evt;
	logic [pspf_pkg::EV_W-1:0] statClr;
	logic                      ceClr;
	logic                      riPend;

	// ==========================================================
	// FIFO storage
	pspf_fifo_mem #(.AW(AW), .DW(pspf_pkg::BYTE_W)) u_mem (
		.mclk (mclk),
		.mp   (memIf.mem)
	);

	assign memIf.we    = push;
	assign memIf.waddr = st_reg.wrPtr;
	assign memIf.wdata = frame[8:1];
	assign memIf.raddr = st_reg.rdPtr;

	// ==========================================================
	// Outputs
	assign prdata    = st_reg.prdata;
	assign pready    = st_reg.pready;
	assign pslverr   = st_reg.pslverr;
	assign irq       = st_reg.irq;
	assign ps2ClkOeN = st_reg.clkOeN;
	assign ps2ClkOut = st_reg.clkOeN;
	assign ps2DatOeN = st_reg.datOeN;
	assign ps2DatOut = st_reg.datOeN;
	assign riPend    = st_reg.re && st_reg.cnt != '0;

	// ==========================================================
	// Next state
	always_comb begin
		st_next = st_reg;
		push    = 1'b0;
		pop     = 1'b0;
		txFail  = 1'b0;
		txOk    = 1'b0;
		evt     = '0;
		statClr = '0;
		ceClr   = 1'b0;

		// Two-stage synchronisers, third stage for edge finding
		st_next.clkS1 = ps2ClkIn;
		st_next.clkS2 = st_reg.clkS1;
		st_next.clkS3 = st_reg.clkS2;
		st_next.datS1 = ps2DatIn;
		st_next.datS2 = st_reg.datS1;
		fall  = st_reg.clkS3 && !st_reg.clkS2;
		frame = {st_reg.datS2, st_reg.rxSh[10:1]};

		if (st_reg.timer != '0) begin
			st_next.timer = st_reg.timer - 1'b1;
		end

		// Receiver, idle while a command is being sent
		if (st_reg.tx != pspf_pkg::TX_IDLE) begin
			st_next.rxBits = '0;
		end else if (fall) begin
			st_next.rxSh  = frame;
			st_next.timer = TMO;
			if (st_reg.rxBits == pspf_pkg::FRAME_LAST) begin
				st_next.rxBits = '0;
				if (!frame[0] && frame[10] && ^frame[9:1]
				    && st_reg.cnt != FULL_CNT) begin
					push = 1'b1;
					evt[pspf_pkg::EV_RX] = 1'b1;
				end else begin
					evt[pspf_pkg::EV_RXERR] = 1'b1;
				end
			end else begin
				st_next.rxBits = st_reg.rxBits + 1'b1;
			end
		end else if (st_reg.rxBits != '0 && st_reg.timer == '0) begin
			st_next.rxBits = '0;
		end

		// Command sender
		case (st_reg.tx)
			pspf_pkg::TX_IDLE: begin
			end
			pspf_pkg::TX_INHIBIT: begin
				if (st_reg.timer == '0) begin
					st_next.datOeN = 1'b0;
					st_next.tx     = pspf_pkg::TX_START;
				end
			end
			pspf_pkg::TX_START: begin
				st_next.clkOeN = 1'b1;
				st_next.timer  = TMO;
				st_next.tx     = pspf_pkg::TX_BITS;
			end
			pspf_pkg::TX_BITS: begin
				if (fall) begin
					st_next.datOeN = st_reg.txSh[0];
					st_next.txSh   = {1'b1, st_reg.txSh[9:1]};
					st_next.txBits = st_reg.txBits + 1'b1;
					if (st_reg.txBits == pspf_pkg::TX_LAST) begin
						st_next.tx = pspf_pkg::TX_ACK;
					end
				end else if (st_reg.timer == '0) begin
					txFail = 1'b1;
				end
			end
			pspf_pkg::TX_ACK: begin
				if (fall) begin
					txFail = st_reg.datS2;
					txOk   = !st_reg.datS2;
				end else if (st_reg.timer == '0) begin
					txFail = 1'b1;
				end
			end
			default: begin
				txFail = 1'b1;
			end
		endcase
		if (txFail || txOk) begin
			st_next.tx     = pspf_pkg::TX_IDLE;
			st_next.clkOeN = 1'b1;
			st_next.datOeN = 1'b1;
			evt[pspf_pkg::EV_TXERR] = txFail;
			evt[pspf_pkg::EV_TXOK]  = txOk;
		end

		// APB: setup, one wait cycle, then completion
		st_next.pready  = 1'b0;
		st_next.pslverr = 1'b0;
		if (psel && penable && !st_reg.pready) begin
			st_next.pready  = 1'b1;
			st_next.prdata  = '0;
			st_next.popPend = 1'b0;
			case (paddr)
				pspf_pkg::DATA_ADDR: begin
					if (!pwrite && st_reg.cnt != '0) begin
						st_next.popPend = 1'b1;
						st_next.prdata[pspf_pkg::VALID_BIT] = 1'b1;
						st_next.prdata[pspf_pkg::BYTE_W-1:0] =
							memIf.rdata;
					end
					st_next.prdata[pspf_pkg::CNT_LSB +: pspf_pkg::CNT_W] =
						pspf_pkg::CNT_W'(st_reg.cnt);
				end
				pspf_pkg::CTRL_ADDR: begin
					st_next.prdata[pspf_pkg::RE_BIT] = st_reg.re;
					st_next.prdata[pspf_pkg::RI_BIT] = riPend;
					st_next.prdata[pspf_pkg::CE_BIT] = st_reg.ce;
				end
				pspf_pkg::STAT_ADDR: begin
					st_next.prdata[pspf_pkg::EV_W-1:0] = st_reg.stat;
				end
				pspf_pkg::MASK_ADDR: begin
					st_next.prdata[pspf_pkg::EV_W-1:0] = st_reg.mask;
				end
				default: begin
					st_next.pslverr = 1'b1;
				end
			endcase
		end
		if (psel && penable && st_reg.pready) begin
			st_next.popPend = 1'b0;
			if (!pwrite) begin
				pop = st_reg.popPend;
			end else begin
				case (paddr)
					pspf_pkg::DATA_ADDR: begin
						if (st_reg.tx == pspf_pkg::TX_IDLE) begin
							st_next.tx     = pspf_pkg::TX_INHIBIT;
							st_next.clkOeN = 1'b0;
							st_next.timer  = INH;
							st_next.txBits = '0;
							st_next.rxBits = '0;
							st_next.txSh   = {1'b1, ~^pwdata[7:0],
								pwdata[7:0]};
						end else begin
							txFail = 1'b1;
							evt[pspf_pkg::EV_TXERR] = 1'b1;
						end
					end
					pspf_pkg::CTRL_ADDR: begin
						st_next.re = pwdata[pspf_pkg::RE_BIT];
						ceClr      = pwdata[pspf_pkg::CE_BIT];
					end
					pspf_pkg::STAT_ADDR: begin
						statClr = pwdata[pspf_pkg::EV_W-1:0];
					end
					pspf_pkg::MASK_ADDR: begin
						st_next.mask = pwdata[pspf_pkg::EV_W-1:0];
					end
					default: begin
					end
				endcase
			end
		end

		// FIFO pointers and count
		st_next.wrPtr = st_reg.wrPtr + AW'(push);
		st_next.rdPtr = st_reg.rdPtr + AW'(pop);
		st_next.cnt   = st_reg.cnt + CW'(push) - CW'(pop);

		// Sticky flags, a set beats a clear in the same cycle
		st_next.stat = (st_reg.stat & ~statClr) | evt;
		st_next.ce   = (st_reg.ce & ~ceClr) | evt[pspf_pkg::EV_TXERR];
		st_next.irq  = (st_next.re && st_next.cnt != '0)
			|| |(st_next.stat & st_next.mask);
	end

	// ==========================================================
	// State register
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			st_reg        <= '0;
			st_reg.tx     <= pspf_pkg::TX_IDLE;
			st_reg.clkOeN <= 1'b1;
			st_reg.datOeN <= 1'b1;
			st_reg.clkS1  <= 1'b1;
			st_reg.clkS2  <= 1'b1;
			st_reg.clkS3  <= 1'b1;
			st_reg.datS1  <= 1'b1;
			st_reg.datS2  <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (sys_rst);

	property p_wait_state;
		psel && penable && !pready |=> pready ##1 !pready;
	endproperty
	a_wait_state: assert property (p_wait_state)
		else $error("answer did not follow one wait cycle");

	property p_valid_count;
		pready && !pwrite && paddr == pspf_pkg::DATA_ADDR
			&& prdata[pspf_pkg::VALID_BIT]
			|-> prdata[pspf_pkg::CNT_LSB +: pspf_pkg::CNT_W] != '0;
	endproperty
	a_valid_count: assert property (p_valid_count)
		else $error("valid read reported zero entries");

	property p_pop;
		psel && penable && pready && !pwrite
			&& paddr == pspf_pkg::DATA_ADDR && prdata[pspf_pkg::VALID_BIT]
			|=> st_reg.rdPtr == $past(st_reg.rdPtr) + 1'b1;
	endproperty
	a_pop: assert property (p_pop)
		else $error("valid read did not remove head entry");

	property p_no_pop;
		psel && penable && pready && !pwrite
			&& !prdata[pspf_pkg::VALID_BIT]
			|=> $stable(st_reg.rdPtr);
	endproperty
	a_no_pop: assert property (p_no_pop)
		else $error("invalid read removed an entry");

	property p_depth;
		st_reg.cnt <= FULL_CNT;
	endproperty
	a_depth: assert property (p_depth)
		else $error("FIFO count above depth");

	property p_irq;
		st_reg.re && st_reg.cnt != '0 |-> irq;
	endproperty
	a_irq: assert property (p_irq)
		else $error("interrupt low with data and enable");

	property p_ri_clear;
		$fell(riPend) && $past(st_reg.re) && st_reg.re
			|-> st_reg.cnt == '0;
	endproperty
	a_ri_clear: assert property (p_ri_clear)
		else $error("pending cleared with entries left");

	property p_cmd_start;
		psel && penable && pready && pwrite
			&& paddr == pspf_pkg::DATA_ADDR
			&& st_reg.tx == pspf_pkg::TX_IDLE
			|=> st_reg.tx == pspf_pkg::TX_INHIBIT && !ps2ClkOeN;
	endproperty
	a_cmd_start: assert property (p_cmd_start)
		else $error("command write did not start sending");

	property p_nack;
		st_reg.tx == pspf_pkg::TX_ACK && fall && st_reg.datS2
			|=> st_reg.ce && st_reg.tx == pspf_pkg::TX_IDLE;
	endproperty
	a_nack: assert property (p_nack)
		else $error("missing acknowledge did not flag error");

	property p_parity;
		push |-> ^frame[9:1] && !frame[0] && frame[10];
	endproperty
	a_parity: assert property (p_parity)
		else $error("bad frame stored in FIFO");

endmodule : pspf_port

// >>> dv/pspf_dev_model.sv
// Behavioural keyboard/mouse device on the open-drain serial link
`timescale 1ns/100ps
module pspf_dev_model (
	input  wire logic       clkLine,
	input  wire logic       datLine,
	input  wire logic       nack,
	output logic            clkOeN,
	output logic            datOeN,
	output logic [7:0]      lastCmd,
	output logic            parOk
);
	logic [9:0] sh;

	initial begin
		clkOeN = 1'b1;
		datOeN = 1'b1;
		lastCmd = 8'h00;
		parOk = 1'b0;
	end

	// ==========================================================
	// Device to host frame, clock stands high between frames
	task automatic send_byte(input logic [7:0] b);
		logic [10:0] f;
		f = {1'b1, ~^b, b, 1'b0};
		// Keep link edges off the host clock edges
		#10;
		for (int i = 0; i < 11; i++) begin
			datOeN = f[i];
			#80 clkOeN = 1'b0;
			#160 clkOeN = 1'b1;
			#80;
		end
		datOeN = 1'b1;
		#390;
	endtask : send_byte

	// ==========================================================
	// Host request to send: inhibit, data low, clock released
	always begin
		wait (!clkLine && clkOeN);
		wait (clkLine && !datLine && datOeN);
		#90;
		for (int i = 0; i < 10; i++) begin
			#80 clkOeN = 1'b0;
			#160 clkOeN = 1'b1;
			sh[i] = datLine;
		end
		// Result is ready before the acknowledge clock
		lastCmd = sh[7:0];
		parOk = (^sh[8:0]) && sh[9];
		// Acknowledge low, or held high when told to refuse
		datOeN = nack;
		#80 clkOeN = 1'b0;
		#160 clkOeN = 1'b1;
		datOeN = 1'b1;
	end
endmodule : pspf_dev_model

// >>> dv/ps2_port_rx_fifo_test.sv
// Self-checking bench for the serial keyboard/mouse port
`timescale 1ns/100ps
module ps2_port_rx_fifo_test;
	localparam int DEPTH = 8;
	localparam int LIMIT = 40000;
	localparam logic [31:0] ONES = 32'hFFFF_FFFF;
	localparam logic [31:0] NOBYTE = 32'hFFFF_FF00;
	localparam logic [31:0] DAT = pspf_pkg::DATA_ADDR;
	localparam logic [31:0] CTL = pspf_pkg::CTRL_ADDR;
	localparam logic [31:0] STA = pspf_pkg::STAT_ADDR;

	logic        mclk, sys_rst, psel, penable, pwrite;
	logic        pready, pslverr, irq, nack, parOk;
	logic [31:0] paddr, pwdata, prdata, rnd;
	logic        clkOeN, datOeN, devClkOeN, devDatOeN, clkOut, datOut;
	logic [7:0]  lastCmd;
	logic [32:0] expQ[$];
	logic [32:0] mskQ[$];
	logic [7:0]  bq[$];
	int          err_count, num_checks, cyc;
	wire logic   clkLine;
	wire logic   datLine;

	// Open-drain wires with pull-up
	assign clkLine = clkOeN & devClkOeN;
	assign datLine = datOeN & devDatOeN;

	pspf_port #(.DEPTH(DEPTH), .TIMEOUT_CYC(2000)) u_pspf_port (
		.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ps2ClkIn(clkLine),
		.ps2ClkOut(clkOut), .ps2ClkOeN(clkOeN), .ps2DatIn(datLine),
		.ps2DatOut(datOut), .ps2DatOeN(datOeN), .irq(irq));

	pspf_dev_model u_pspf_dev_model (
		.clkLine(clkLine), .datLine(datLine), .nack(nack),
		.clkOeN(devClkOeN), .datOeN(devDatOeN), .lastCmd(lastCmd),
		.parOk(parOk));

	always #20 mclk = ~mclk;

	// ==========================================================
	// Helpers
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] x;
		x = v ^ (v << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs

	function automatic logic [31:0] dw(input int n, input logic [7:0] b);
		return {n[15:0], 1'b1, 7'h00, b};
	endfunction : dw

	task automatic chk(input string nm, input logic [32:0] s, e);
		num_checks++;
		if (s !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	task automatic irq_is(input logic e);
		chk("irq", {32'h0, irq}, {32'h0, e});
	endtask : irq_is

	task automatic print_verdict;
		if (err_count == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : print_verdict

	task automatic apb(input logic w, input logic [31:0] a, d,
			input logic [32:0] e, m);
		expQ.push_back(e);
		mskQ.push_back(m);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rd(input logic [31:0] a, e, m);
		apb(1'b0, a, 32'h0, {1'b0, e}, {1'b1, m});
	endtask : rd

	task automatic wr(input logic [31:0] a, d);
		apb(1'b1, a, d, 33'h0, 33'h1_0000_0000);
	endtask : wr

	// ==========================================================
	// Response monitor and timeout
	always @(posedge mclk) begin
		if (psel && penable && pready === 1'b1) begin
			chk("apb", {pslverr, prdata} & mskQ[0], expQ[0] & mskQ[0]);
			void'(expQ.pop_front());
			void'(mskQ.pop_front());
		end
		if (!sys_rst) begin
			chk("pinout", {31'h0, clkOut, datOut},
				{31'h0, clkOeN, datOeN});
		end
	end

	always @(posedge mclk) begin
		cyc++;
		if (cyc == LIMIT) begin
			err_count++;
			print_verdict();
		end
	end

	// ==========================================================
	// Main sequence
	initial begin
		mclk = 1'b0;
		sys_rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0;
		pwdata = 32'h0;
		nack = 1'b0;
		rnd = 32'h6937;
		err_count = 0;
		num_checks = 0;
		cyc = 0;
		repeat (2) @(posedge mclk);
		sys_rst <= 1'b0;
		rd(CTL, 32'h0, ONES);
		rd(DAT, 32'h0, NOBYTE);
		apb(1'b0, 32'hFF20_0118, 32'h0, 33'h1_0000_0000, {33{1'b1}});
		irq_is(1'b0);
		// One frame more than the FIFO holds
		for (int i = 0; i <= DEPTH; i++) begin
			rnd = xs(rnd);
			bq.push_back(rnd[7:0]);
			u_pspf_dev_model.send_byte(rnd[7:0]);
		end
		repeat (6) @(posedge mclk);
		rd(CTL, 32'h0, ONES);
		wr(CTL, 32'h1);
		repeat (2) @(posedge mclk);
		irq_is(1'b1);
		rd(CTL, 32'h101, ONES);
		for (int i = 0; i < DEPTH; i++)
			rd(DAT, dw(DEPTH - i, bq[i]), ONES);
		rd(DAT, 32'h0, NOBYTE);
		rd(CTL, 32'h1, ONES);
		rd(STA, 32'h9, ONES);
		irq_is(1'b0);
		wr(STA, 32'hF);
		// Command accepted, then refused by the device
		for (int k = 0; k < 2; k++) begin
			nack = k[0];
			rnd = xs(rnd);
			wr(pspf_pkg::MASK_ADDR, 32'h6);
			rd(pspf_pkg::MASK_ADDR, 32'h6, ONES);
			wr(DAT, rnd);
			while (irq !== 1'b1) @(posedge mclk);
			chk("cmd", {25'h0, lastCmd}, {25'h0, rnd[7:0]});
			chk("parity", {32'h0, parOk}, 33'h1);
			rd(STA, k ? 32'h4 : 32'h2, ONES);
			rd(CTL, k ? 32'h400 : 32'h1, ONES);
			wr(STA, 32'hF);
			wr(CTL, 32'h400);
			rd(CTL, 32'h0, ONES);
		end
		repeat (2) @(posedge mclk);
		irq_is(1'b0);
		print_verdict();
	end
endmodule : ps2_port_rx_fifo_test
